// ---- cmpe_assertions.sv ----
// port checker for the comparator event block
`timescale 1ns/1ps
`include "cmpe_defs.svh"
module cmpe_assertions
(
	// clock, reset and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// comparator, power state, interrupts
	input wire logic        comparator_power_on,
	input wire logic        idle_mode,
	input wire logic        power_down,
	input wire logic        comparator_irq,
	input wire logic        irq
);
	// ----------------
	// register shadows
	// ----------------
	logic       acc, wr, mapped;
	logic [7:0] ctrl_q, mask_q, sys_q;
	assign acc = psel && penable;
	assign wr = acc && pwrite && pstrb[0];
	assign mapped = paddr inside {`CMPE_CTRL_ADDR, `CMPE_IRQ_STAT_ADDR, `CMPE_IRQ_MASK_ADDR,
		`CMPE_SYS_ADDR, `CMPE_STATE_ADDR};
	// shadows follow software writes so outputs can be tied to their cause
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 8'h00;
			mask_q <= 8'h00;
			sys_q <= 8'h00;
		end
		else if (wr)
		begin
			if (paddr == `CMPE_CTRL_ADDR)
				ctrl_q <= pwdata[7:0];
			if (paddr == `CMPE_IRQ_MASK_ADDR)
				mask_q <= pwdata[7:0];
			if (paddr == `CMPE_SYS_ADDR)
				sys_q <= pwdata[7:0];
		end
	end
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	pready_up_a: assert property (pready)
		else $error("pready low");
	slverr_map_a: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	rdata_idle_a: assert property (!acc |-> prdata == 32'h0000_0000)
		else $error("read data outside access phase");
	irq_gate_a: assert property (!sys_q[0] |-> !comparator_irq)
		else $error("comparator irq without enable");
	off_gate_a: assert property (!ctrl_q[3] |-> !comparator_power_on)
		else $error("comparator active while disabled");
	pd_gate_a: assert property (power_down [*3] |-> !comparator_power_on)
		else $error("comparator active in power down");
	idle_gate_a: assert property (idle_mode [*3] ##0 !ctrl_q[7] |-> !comparator_power_on)
		else $error("comparator active in gated idle");
	run_on_a: assert property ((ctrl_q[3] && !power_down && !idle_mode) [*3] |-> comparator_power_on)
		else $error("comparator not active when enabled");
	irq_mask_a: assert property (mask_q[1:0] == 2'b00 |-> !irq)
		else $error("irq with all sources masked");
	flag_hold_a: assert property ($fell(comparator_irq) |-> $past(wr))
		else $error("event flag dropped without software");
	stat_hold_a: assert property ($fell(irq) |-> $past(wr))
		else $error("irq dropped without software");
	cover property ($rose(comparator_irq));
	cover property ($rose(irq) && !comparator_irq);
	cover property (acc && pslverr);
endmodule
bind cmpe_top cmpe_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .comparator_power_on, .idle_mode, .power_down,
	.comparator_irq, .irq);

// ---- cmpe_defs.svh ----
// register offsets, field positions and timing constants for the comparator event block
`ifndef CMPE_DEFS_SVH
`define CMPE_DEFS_SVH

// register byte addresses (printed offset 0x97 is not a multiple of four: index * 4)
`define CMPE_CTRL_INDEX     8'h97
`define CMPE_CTRL_ADDR      12'h25C
`define CMPE_IRQ_STAT_ADDR  12'h000
`define CMPE_IRQ_MASK_ADDR  12'h004
`define CMPE_SYS_ADDR       12'h008
`define CMPE_STATE_ADDR     12'h00C

// control/status fields
`define CMPE_MODE_LSB       0
`define CMPE_MODE_MSB       2
`define CMPE_EN_BIT         3
`define CMPE_FLAG_BIT       4
`define CMPE_IDLE_BIT       7
`define CMPE_CTRL_RESET     8'h00
`define CMPE_CTRL_WMASK     8'h9F

// system control fields
`define CMPE_SYS_IE_BIT     0
`define CMPE_SYS_IDLE_BIT   1
`define CMPE_SYS_PD_BIT     2

// machine cycle: twelve clocks, sample taken in the fourth state
`define CMPE_MC_CLOCKS      12
`define CMPE_S4_CLOCK       7
`define CMPE_DEB_OVF        2

`endif

// ---- cmpe_partner.sv ----
// analog comparator core and timer overflow model
`timescale 1ns/1ps
module cmpe_partner
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// analog levels and timer period
	input  wire logic [15:0] pos_level,
	input  wire logic [15:0] neg_level,
	input  wire logic [15:0] ovf_period,
	// block side
	input  wire logic        comparator_power_on,
	output logic             raw_compare,
	output logic             timer_overflow
);
	logic [15:0] tick_q;
	logic        junk_q;
	// high only above; unpowered core gives junk so gating is exercised
	assign raw_compare = comparator_power_on ? (pos_level > neg_level) : junk_q;
	// free running timer, one overflow pulse per programmed period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_q <= 16'h0000;
			junk_q <= 1'b0;
			timer_overflow <= 1'b0;
		end
		else
		begin
			junk_q <= !junk_q;
			timer_overflow <= (tick_q == ovf_period - 16'h0001);
			tick_q <= (tick_q >= ovf_period - 16'h0001) ? 16'h0000 : tick_q + 16'h0001;
		end
	end
endmodule

// ---- cmpe_pkg.sv ----
// types shared by the comparator event block
package cmpe_pkg;

	typedef enum logic [2:0] {
		CMPE_LOW_LEVEL,
		CMPE_RISE,
		CMPE_TOGGLE_DEB,
		CMPE_RISE_DEB,
		CMPE_FALL,
		CMPE_TOGGLE,
		CMPE_FALL_DEB,
		CMPE_HIGH_LEVEL
	} cmpe_mode_e;

	typedef enum logic [1:0] {
		CMPE_IDLE,
		CMPE_WAIT1,
		CMPE_WAIT2
	} cmpe_deb_e;

endpackage

// ---- cmpe_tb.sv ----
// self-checking testbench for the comparator event block
`timescale 1ns/1ps
`include "cmpe_defs.svh"
module testbench;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        idle_mode = 1'b0, power_down = 1'b0, pready, pslverr, err, l0;
	logic        raw_compare, comparator_power_on, timer_overflow, comparator_irq, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0]  pstrb = 4'h1;
	logic [15:0] pos_level = 16'h0000, neg_level = 16'h8000, ovf_period = 16'h0014;
	int          error_cnt = 0, compares = 0;
	always #12.5 pclk = !pclk;
	cmpe_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .raw_compare, .comparator_power_on, .timer_overflow, .idle_mode,
		.power_down, .comparator_irq, .irq);
	cmpe_partner far (.pclk, .presetn, .pos_level, .neg_level, .ovf_period,
		.comparator_power_on, .raw_compare, .timer_overflow);
	// ------------
	// bench tasks
	// ------------
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			error_cnt++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic flag_is(input logic e);
		apb(`CMPE_CTRL_ADDR, 1'b0, 32'h0000_0000);
		chk_bit(rd[4], e);
	endtask
	// random levels; equal inputs must read as low
	task automatic lvl(input logic hi);
		@(posedge pclk);
		neg_level <= 16'h4000 + 16'($urandom % 16'h8000);
		pos_level <= hi ? 16'hC001 + 16'($urandom % 16'h0FFF) : 16'h4000 - 16'($urandom % 16'h1000);
	endtask
	// steady level l0, then one change: which modes must have flagged
	function automatic logic exp_flag(input logic [2:0] m, input logic l);
		case (m)
			3'h1, 3'h3: return !l;
			3'h4, 3'h6: return l;
			default: return 1'b1;
		endcase
	endfunction
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#400_000;
		error_cnt++;
		conclude;
	end
	// ----------
	// test flow
	// ----------
	initial
	begin
		void'($urandom(32'h0000_26a0));
		ovf_period = 16'h0014 + 16'($urandom % 16);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(`CMPE_CTRL_ADDR, 1'b0, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(12'h010, 1'b1, 32'hFFFF_FFFF);
		chk_bit(err, 1'b1);
		apb(`CMPE_CTRL_ADDR, 1'b1, 32'hFFFF_FFE0);
		apb(`CMPE_CTRL_ADDR, 1'b0, 32'h0000_0000);
		chk(rd, 32'h0000_0080);
		apb(`CMPE_IRQ_MASK_ADDR, 1'b1, 32'h0000_0001);
		apb(`CMPE_SYS_ADDR, 1'b1, 32'h0000_0001);
		$display("test registers done");
		for (int m = 0; m < 8; m++)
		begin
			l0 = 1'($urandom);
			lvl(l0);
			repeat (20) @(posedge pclk);
			apb(`CMPE_CTRL_ADDR, 1'b1, {29'h0000_0001, 3'(m)});
			repeat (60) @(posedge pclk);
			lvl(!l0);
			repeat (120) @(posedge pclk);
			flag_is(exp_flag(3'(m), l0));
			chk_bit(comparator_irq, exp_flag(3'(m), l0));
			chk_bit(irq, exp_flag(3'(m), l0));
			apb(`CMPE_CTRL_ADDR, 1'b1, {29'h0000_0001, 3'(m)});
			repeat (60) @(posedge pclk);
			flag_is((m == 0 && l0) || (m == 7 && !l0));
			apb(`CMPE_CTRL_ADDR, 1'b1, 32'h0000_0000);
			apb(`CMPE_IRQ_STAT_ADDR, 1'b1, 32'h0000_0003);
			@(negedge pclk);
			chk_bit(irq, 1'b0);
		end
		$display("test modes done");
		lvl(1'b0);
		apb(`CMPE_IRQ_MASK_ADDR, 1'b1, 32'h0000_0002);
		apb(`CMPE_CTRL_ADDR, 1'b1, 32'h0000_000B);
		repeat (30) @(posedge pclk);
		lvl(1'b1);
		repeat (16) @(posedge pclk);
		lvl(1'b0);
		repeat (120) @(posedge pclk);
		flag_is(1'b0);
		apb(`CMPE_IRQ_STAT_ADDR, 1'b0, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		chk_bit(irq, 1'b1);
		apb(`CMPE_IRQ_STAT_ADDR, 1'b1, 32'h0000_0002);
		@(negedge pclk);
		chk_bit(irq, 1'b0);
		$display("test glitch done");
		for (int g = 0; g < 4; g++)
		begin
			power_down <= (g == 1);
			idle_mode <= (g >= 2);
			apb(`CMPE_CTRL_ADDR, 1'b1, g == 0 ? 32'h0000_0005 : g == 3 ? 32'h0000_008D : 32'h0000_000D);
			repeat (20) @(posedge pclk);
			lvl(1'b1);
			repeat (40) @(posedge pclk);
			lvl(1'b0);
			repeat (40) @(posedge pclk);
			flag_is(g == 3);
		end
		apb(`CMPE_SYS_ADDR, 1'b1, 32'h0000_0000);
		@(negedge pclk);
		chk_bit(comparator_irq, 1'b0);
		flag_is(1'b1);
		$display("test gating done");
		conclude;
	end
endmodule

// ---- cmpe_top.sv ----
// comparator event logic with apb register access and interrupt
//
// Overview of operation
// R1 - comparator result is high only when positive input exceeds negative input
// R2 - enable clear forces result low and blocks all event flag setting
// R3 - software waits 10 us after enable and clears flag before interrupt
// R4 - flag sets when enabled sample meets the mode condition
// R5 - hardware never clears the flag; software writes zero to acknowledge
// R6 - three-bit mode picks level, edge, toggle or debounced condition
// R7 - result is sampled once per machine cycle in the fourth state
// R8 - debounced modes wait two timer overflows then confirm expected level
// R9 - debounced event is flagged one to two timer periods after edge
// R10 - software tunes the debounce length through the timer period
// R11 - idle bit chooses gating off or running on during idle
// R12 - power-down stops sampling and event generation
// R13 - processor interrupt needs the interrupt enable bit; flag unaffected (comparator_irq obeys it; irq is gated by irq_mask_q only)
// R14 - edges compare current and previous sample; reload on enabling
// R15 - level modes set the flag again while level still matches
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "cmpe_defs.svh"

module cmpe_top
(
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// analog comparator core
	input  wire logic        raw_compare,
	output logic             comparator_power_on,
	// timer overflow strobe, same clock
	input  wire logic        timer_overflow,
	// system power state
	input  wire logic        idle_mode,
	input  wire logic        power_down,
	// interrupts
	output logic             comparator_irq,
	output logic             irq
);

	// ------------------------------------------------------------
	// registers and internal state
	// ------------------------------------------------------------
	logic [7:0]             comparator_ctrl_status_q;
	logic                   interrupt_enable_q;
	logic [1:0]             irq_stat_q;
	logic [1:0]             irq_mask_q;
	logic [3:0]             mc_cnt_q;
	logic                   cmp_sync1_q;
	logic                   cmp_sync2_q;
	logic                   sample_q;
	logic                   prev_q;
	logic                   en_prev_q;
	logic [1:0]             settle_q;
	logic                   expect_q;
	cmpe_pkg::cmpe_deb_e    deb_q;
	logic                   idle_s1_q;
	logic                   idle_s2_q;
	logic                   pd_s1_q;
	logic                   pd_s2_q;

	logic                   enabled;
	logic                   active;
	logic                   s4_tick;
	logic                   cur;
	logic                   rise;
	logic                   fall;
	logic                   event_hit;
	logic                   flag_clr;
	cmpe_pkg::cmpe_mode_e   mode;
	logic                   wr_en;
	logic                   rd_en;
	logic                   addr_ok;

	// ------------------------------------------------------------
	// apb access
	// ------------------------------------------------------------
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign addr_ok = (paddr == `CMPE_CTRL_ADDR) || (paddr == `CMPE_IRQ_STAT_ADDR)
		|| (paddr == `CMPE_IRQ_MASK_ADDR) || (paddr == `CMPE_SYS_ADDR)
		|| (paddr == `CMPE_STATE_ADDR);
	assign pslverr = psel && penable && !addr_ok;

	// read data is combinational, not registered; pready is immediate so decode here
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_en)
		begin
			unique case (paddr)
				`CMPE_CTRL_ADDR:     prdata = {24'h00_0000, comparator_ctrl_status_q};
				`CMPE_IRQ_STAT_ADDR: prdata = {30'h0000_0000, irq_stat_q};
				`CMPE_IRQ_MASK_ADDR: prdata = {30'h0000_0000, irq_mask_q};
				`CMPE_SYS_ADDR:      prdata = {31'h0000_0000, interrupt_enable_q};
				`CMPE_STATE_ADDR:    prdata = {28'h000_0000, deb_q, prev_q, cur};
				default:             prdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_sync1_q <= 1'b0;
			cmp_sync2_q <= 1'b0;
			idle_s1_q   <= 1'b0;
			idle_s2_q   <= 1'b0;
			pd_s1_q     <= 1'b0;
			pd_s2_q     <= 1'b0;
		end
		else
		begin
			cmp_sync1_q <= raw_compare;
			cmp_sync2_q <= cmp_sync1_q;
			idle_s1_q   <= idle_mode;
			idle_s2_q   <= idle_s1_q;
			pd_s1_q     <= power_down;
			pd_s2_q     <= pd_s1_q;
		end
	end

	// ------------------------------------------------------------
	// gating: enable, idle and power-down
	// ------------------------------------------------------------
	assign mode    = cmpe_pkg::cmpe_mode_e'(
		comparator_ctrl_status_q[`CMPE_MODE_MSB:`CMPE_MODE_LSB]);
	assign enabled = comparator_ctrl_status_q[`CMPE_EN_BIT];
	// R11 idle gating choice; R12 power-down stop
	assign active  = enabled && !pd_s2_q
		&& (!idle_s2_q || comparator_ctrl_status_q[`CMPE_IDLE_BIT]);
	assign comparator_power_on = active;
	// R1 core output high when positive above negative; R2 forced low when off
	assign cur = active ? sample_q : 1'b0;

	// ------------------------------------------------------------
	// machine cycle timing
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mc_cnt_q <= 4'h0;
		else if (mc_cnt_q == 4'(`CMPE_MC_CLOCKS - 1))
			mc_cnt_q <= 4'h0;
		else
			mc_cnt_q <= mc_cnt_q + 4'h1;
	end
	// samples count only once the synchroniser holds post-enable values
	assign s4_tick = (mc_cnt_q == 4'(`CMPE_S4_CLOCK)) && active && (settle_q == 2'b11);

	// R7 one sample per machine cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sample_q <= 1'b0;
		else if (!active)
			sample_q <= 1'b0;
		else if (s4_tick)
			sample_q <= cmp_sync2_q;
	end

	// R14 previous sample; first settled tick after enabling only primes it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_q    <= 1'b0;
			en_prev_q <= 1'b0;
			settle_q  <= 2'b00;
		end
		else if (!active)
		begin
			en_prev_q <= 1'b0;
			settle_q  <= 2'b00;
		end
		else
		begin
			if (settle_q != 2'b11)
				settle_q <= settle_q + 2'b01;
			if (s4_tick)
			begin
				prev_q    <= cmp_sync2_q;
				en_prev_q <= 1'b1;
			end
		end
	end

	// R14 edge from current versus previous sample
	assign rise = s4_tick && en_prev_q && cmp_sync2_q && !prev_q;
	assign fall = s4_tick && en_prev_q && !cmp_sync2_q && prev_q;

	// ------------------------------------------------------------
	// debounce sequencer
	// ------------------------------------------------------------
	// R8 wait two overflows then resample; R9 free timer gives 1 to 2 periods
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			deb_q    <= cmpe_pkg::CMPE_IDLE;
			expect_q <= 1'b0;
		end
		else if (!active)
			deb_q <= cmpe_pkg::CMPE_IDLE;
		else
		begin
			unique case (deb_q)
				cmpe_pkg::CMPE_IDLE:
				begin
					if ((rise && (mode == cmpe_pkg::CMPE_RISE_DEB
						|| mode == cmpe_pkg::CMPE_TOGGLE_DEB))
						|| (fall && (mode == cmpe_pkg::CMPE_FALL_DEB
						|| mode == cmpe_pkg::CMPE_TOGGLE_DEB)))
					begin
						deb_q    <= cmpe_pkg::CMPE_WAIT1;
						expect_q <= rise;
					end
				end
				cmpe_pkg::CMPE_WAIT1:
					if (timer_overflow)
						deb_q <= cmpe_pkg::CMPE_WAIT2;
				cmpe_pkg::CMPE_WAIT2:
					if (timer_overflow)
						deb_q <= cmpe_pkg::CMPE_IDLE;
				default:
					deb_q <= cmpe_pkg::CMPE_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// event condition
	// ------------------------------------------------------------
	// R4 R6 mode decode; R15 levels fire on every matching sample
	always_comb
	begin
		event_hit = 1'b0;
		unique case (mode)
			cmpe_pkg::CMPE_LOW_LEVEL:  event_hit = s4_tick && !cmp_sync2_q;
			cmpe_pkg::CMPE_HIGH_LEVEL: event_hit = s4_tick && cmp_sync2_q;
			cmpe_pkg::CMPE_RISE:       event_hit = rise;
			cmpe_pkg::CMPE_FALL:       event_hit = fall;
			cmpe_pkg::CMPE_TOGGLE:     event_hit = rise || fall;
			default:
				// R8 confirm expected level at second overflow, else dropped
				event_hit = (deb_q == cmpe_pkg::CMPE_WAIT2) && timer_overflow
					&& (cmp_sync2_q == expect_q);
		endcase
		// R2 nothing sets the flag while disabled
		if (!active)
			event_hit = 1'b0;
	end

	// ------------------------------------------------------------
	// control/status register
	// ------------------------------------------------------------
	assign flag_clr = wr_en && pstrb[0] && (paddr == `CMPE_CTRL_ADDR)
		&& !pwdata[`CMPE_FLAG_BIT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			comparator_ctrl_status_q <= `CMPE_CTRL_RESET;
		else
		begin
			if (wr_en && pstrb[0] && (paddr == `CMPE_CTRL_ADDR))
				comparator_ctrl_status_q <= (pwdata[7:0] & `CMPE_CTRL_WMASK)
					& ~(8'h01 << `CMPE_FLAG_BIT)
					| (comparator_ctrl_status_q & (8'h01 << `CMPE_FLAG_BIT));
			// R5 only software clears; set wins over clear
			if (flag_clr && !event_hit)
				comparator_ctrl_status_q[`CMPE_FLAG_BIT] <= 1'b0;
			if (event_hit)
				comparator_ctrl_status_q[`CMPE_FLAG_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interrupt_enable_q <= 1'b0;
		else if (wr_en && pstrb[0] && (paddr == `CMPE_SYS_ADDR))
			interrupt_enable_q <= pwdata[`CMPE_SYS_IE_BIT];
	end

	// R13 request reaches the processor only with its enable
	assign comparator_irq = comparator_ctrl_status_q[`CMPE_FLAG_BIT] && interrupt_enable_q;

	// ------------------------------------------------------------
	// sticky status and mask: bit0 event, bit1 debounce discard
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat_q <= 2'b00;
			irq_mask_q <= 2'b00;
		end
		else
		begin
			if (wr_en && pstrb[0] && (paddr == `CMPE_IRQ_MASK_ADDR))
				irq_mask_q <= pwdata[1:0];
			irq_stat_q <= (irq_stat_q
				& ~((wr_en && pstrb[0] && (paddr == `CMPE_IRQ_STAT_ADDR))
				? pwdata[1:0] : 2'b00))
				| {(deb_q == cmpe_pkg::CMPE_WAIT2) && timer_overflow && active
				&& (cmp_sync2_q != expect_q), event_hit};
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

endmodule
